// [logic/uart_efr_defs.vh]
// Constants for the enhanced-feature register group
// Overview of operation
// - Transmit FIFO level reads byte count, read-only
// - Special function register needs key 0xBF, 0x5A
// - Bit 6 selects rx count or error count
// - Bit 4 enables burst register access
// - Bit 3 loops receive path to transmit
// - Bit 2 plus key gates special registers
// - Bit 1 enables automatic DSR/DTR flow control
// - Bit 0 forces continuous transmission
// - Bit 7 disables crystal feedback resistor
// - Control bits 7:4 hold sample clock value
// - Control bit 3 enables in-band Xon
// - Control bit 2 enables transmitter-empty interrupt
// - Bit 1 receive timeout, bit 0 idle insertion
// - Control register resets to 0x06
// - Status bits 7:4 flag their active sources
// - Status bits 3:1 flag receiver sources
// - Writing clear bit clears all status bits except those whose event arrives in the same cycle
// - Prescaler supplies M high nibble, N low
// - Error count reports error bytes in receive FIFO
`ifndef UART_EFR_DEFS_VH
`define UART_EFR_DEFS_VH
`define OFS_PRESCALER       4'h4
`define OFS_RX_COUNT        4'h5
`define OFS_TX_LEVEL        4'h6
`define OFS_SPECIAL         4'h7
`define OFS_IDLE            4'h8
`define OFS_TXRX            4'h9
`define OFS_UNLOCK          4'hD
`define OFS_STATUS          4'hF
`define KEY_LINE            8'hBF
`define KEY_UNLOCK          8'h5A
`define RST_SPECIAL         8'h00
`define RST_IDLE            8'h00
`define RST_TXRX            8'h06
`define RST_STATUS          7'h00
`define RST_PRESCALER       8'h10
`define RST_UNLOCK          8'h00
`define SF_XTAL_OFF         7
`define SF_COUNT_SEL        6
`define SF_BURST            4
`define SF_LOOPBACK         3
`define SF_SPECIAL_EN       2
`define SF_DSR_DTR          1
`define SF_FORCE_TX         0
`define TR_XON              3
`define TR_TX_EMPTY         2
`define TR_RX_TIMEOUT       1
`define TR_IDLE_INS         0
`define ST_CLEAR            0
`endif

// [logic/sticky_status_bit.v]
// One sticky interrupt status flag with a set-wins clear
`timescale 1ns/100ps
`default_nettype none
module sticky_status_bit
(
	// Clock and reset
	input  wire i_clock,
	input  wire i_resetn,
	// Event and clear
	input  wire i_set,
	input  wire i_clear,
	// Flag
	output reg  o_flag
);
	// An event in the clearing cycle is kept, so no source is lost
	always @(posedge i_clock or negedge i_resetn)
	begin
		if (!i_resetn)
			o_flag <= 1'b0;
		else if (i_set)
			o_flag <= 1'b1;
		else if (i_clear)
			o_flag <= 1'b0;
	end
endmodule // sticky_status_bit
`default_nettype wire

// [logic/uart_enhanced_feature_registers.v]
// Enhanced-feature register group with keyed access
`timescale 1ns/100ps
`default_nettype none
`include "uart_efr_defs.vh"
module uart_enhanced_feature_registers #
(
	parameter WIDTH = 8
)
(
	// Clock and reset
	input  wire             i_clock,
	input  wire             i_resetn,
	// Register port from host-side bridge logic
	input  wire [3:0]       i_address,
	input  wire             i_write,
	input  wire             i_read,
	input  wire [WIDTH-1:0] i_write_data,
	output reg  [WIDTH-1:0] o_read_data,
	output wire             o_claimed,
	// Line control value from the ordinary register set
	input  wire [WIDTH-1:0] i_line_control_key,
	// Datapath counters
	input  wire [WIDTH-1:0] i_tx_fifo_level,
	input  wire [WIDTH-1:0] i_rx_fifo_level,
	input  wire [WIDTH-1:0] i_rx_error_byte_count,
	// Interrupt source events, one-cycle pulses
	input  wire [7:1]       i_status_events,
	// Controls to the UART core
	output wire             o_xtal_feedback_disable,
	output wire             o_burst_enable,
	output wire             o_internal_loopback,
	output wire             o_dsr_dtr_flow_enable,
	output wire             o_force_transmit,
	output wire [3:0]       o_prescaler_m,
	output wire [3:0]       o_prescaler_n,
	output wire [WIDTH-1:0] o_tx_idle_time,
	output wire [3:0]       o_sample_clock_value,
	output wire             o_xon_enable,
	output wire             o_tx_empty_int_enable,
	output wire             o_rx_timeout_enable,
	output wire             o_idle_insert_enable,
	output wire [7:1]       o_status_flags
);
	reg  [WIDTH-1:0] special_function_ctrl;
	reg  [WIDTH-1:0] special_unlock_key;
	reg  [WIDTH-1:0] prescaler_reg;
	reg  [WIDTH-1:0] tx_idle_time;
	reg  [WIDTH-1:0] txrx_control;
	reg  [WIDTH-1:0] next_read_data;
	wire             key_ok;
	wire             sf_open;
	wire             special_open;
	wire             hit_unlock;
	wire             hit_sf;
	wire             hit_special;
	wire             clear_all_status;
	wire [7:1]       status_flags;

	// Access gates; a closed gate leaves the address to the ordinary set
	assign key_ok       = (i_line_control_key == `KEY_LINE);
	assign sf_open      = key_ok && (special_unlock_key == `KEY_UNLOCK);
	assign special_open = key_ok && special_function_ctrl[`SF_SPECIAL_EN];
	assign hit_unlock   = key_ok && (i_address == `OFS_UNLOCK);
	assign hit_sf       = sf_open && (i_address == `OFS_SPECIAL);
	assign hit_special  = special_open && ((i_address == `OFS_PRESCALER)
		|| (i_address == `OFS_RX_COUNT) || (i_address == `OFS_TX_LEVEL)
		|| (i_address == `OFS_IDLE) || (i_address == `OFS_TXRX)
		|| (i_address == `OFS_STATUS));
	assign o_claimed    = hit_unlock || hit_sf || hit_special;

	// Writable registers; writes outside an open gate do nothing
	always @(posedge i_clock or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			special_function_ctrl <= `RST_SPECIAL;
			special_unlock_key    <= `RST_UNLOCK;
			prescaler_reg         <= `RST_PRESCALER;
			tx_idle_time          <= `RST_IDLE;
			txrx_control          <= `RST_TXRX;
		end
		else if (i_write)
		begin
			if (hit_unlock)
				special_unlock_key <= i_write_data;
			if (hit_sf)
				special_function_ctrl <= i_write_data;
			if (hit_special && i_address == `OFS_PRESCALER)
				prescaler_reg <= i_write_data;
			if (hit_special && i_address == `OFS_IDLE)
				tx_idle_time <= i_write_data;
			if (hit_special && i_address == `OFS_TXRX)
				txrx_control <= i_write_data;
		end
	end

	// Clear strobe is a write of one to bit 0; bit 0 is never stored
	assign clear_all_status = i_write && hit_special && (i_address == `OFS_STATUS)
		&& i_write_data[`ST_CLEAR];

	// One sticky flag per interrupt source
	genvar g;
	generate
		for (g = 1; g < 8; g = g + 1)
		begin : status_bits
			sticky_status_bit u_bit
			(
				.i_clock  (i_clock),
				.i_resetn (i_resetn),
				.i_set    (i_status_events[g]),
				.i_clear  (clear_all_status),
				.o_flag   (status_flags[g])
			);
		end
	endgenerate

	// Read multiplexer
	always @*
	begin
		next_read_data = {WIDTH{1'b0}};
		if (hit_unlock)
			next_read_data = special_unlock_key;
		else if (hit_sf)
			next_read_data = special_function_ctrl;
		else if (hit_special)
		begin
			case (i_address)
				`OFS_PRESCALER: next_read_data = prescaler_reg;
				`OFS_RX_COUNT:
				begin
					if (special_function_ctrl[`SF_COUNT_SEL])
						next_read_data = i_rx_error_byte_count;
					else
						next_read_data = i_rx_fifo_level;
				end
				`OFS_TX_LEVEL:  next_read_data = i_tx_fifo_level;
				`OFS_IDLE:      next_read_data = tx_idle_time;
				`OFS_TXRX:      next_read_data = txrx_control;
				`OFS_STATUS:    next_read_data = {status_flags, 1'b0};
				default:        next_read_data = {WIDTH{1'b0}};
			endcase
		end
	end

	// Read data registered one cycle after the read strobe
	always @(posedge i_clock or negedge i_resetn)
	begin
		if (!i_resetn)
			o_read_data <= {WIDTH{1'b0}};
		else if (i_read)
			o_read_data <= next_read_data;
	end

	// Control fields to the UART core
	assign o_xtal_feedback_disable = special_function_ctrl[`SF_XTAL_OFF];
	assign o_burst_enable          = special_function_ctrl[`SF_BURST];
	assign o_internal_loopback     = special_function_ctrl[`SF_LOOPBACK];
	assign o_dsr_dtr_flow_enable   = special_function_ctrl[`SF_DSR_DTR];
	assign o_force_transmit        = special_function_ctrl[`SF_FORCE_TX];
	// Baud generator takes M, N and the sample value; IrDA limits are software's
	assign o_prescaler_m           = prescaler_reg[7:4];
	assign o_prescaler_n           = prescaler_reg[3:0];
	assign o_sample_clock_value    = txrx_control[7:4];
	assign o_tx_idle_time          = tx_idle_time;
	assign o_xon_enable            = txrx_control[`TR_XON];
	assign o_tx_empty_int_enable   = txrx_control[`TR_TX_EMPTY];
	assign o_rx_timeout_enable     = txrx_control[`TR_RX_TIMEOUT];
	assign o_idle_insert_enable    = txrx_control[`TR_IDLE_INS];
	assign o_status_flags          = status_flags;
endmodule // uart_enhanced_feature_registers
`default_nettype wire

// [verif/efr_host_model.sv]
// Host bridge model issuing single-byte register cycles
`timescale 1ns/100ps
`default_nettype none
module efr_host_model
(
	// Clock
	input  wire logic       i_clock,
	// Register port towards the block
	output var logic [3:0]  o_address,
	output var logic        o_write,
	output var logic        o_read,
	output var logic [7:0]  o_write_data,
	input  wire logic [7:0] i_read_data
);
	initial
		{o_address, o_write, o_read, o_write_data} = 14'h0000;
	// One write; released data is inverted so stale values are never trusted
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
	begin
		@(posedge i_clock);
		o_address <= a;
		o_write_data <= d;
		o_write <= 1'b1;
		@(posedge i_clock);
		o_write <= 1'b0;
		o_write_data <= ~d;
		#1;
	end
	endtask
	// One read; data is taken once the answering edge has landed
	task automatic rd(input logic [3:0] a, output logic [7:0] q);
	begin
		@(posedge i_clock);
		o_address <= a;
		o_read <= 1'b1;
		@(posedge i_clock);
		o_read <= 1'b0;
		#1;
		q = i_read_data;
	end
	endtask
endmodule // efr_host_model
`default_nettype wire

// [verif/efr_checker_sva.sv]
// Assertions on the enhanced-feature register port
`timescale 1ns/100ps
`default_nettype none
module efr_checker_sva
(
	// Clock, reset and requests
	input wire logic       i_clock,
	input wire logic       i_resetn,
	input wire logic [3:0] i_address,
	input wire logic       i_write,
	input wire logic       i_read,
	input wire logic [7:0] i_write_data,
	input wire logic [7:0] i_line_control_key,
	input wire logic [7:0] i_tx_fifo_level,
	input wire logic [7:1] i_status_events,
	// Answers
	input wire logic [7:0] o_read_data,
	input wire logic       o_claimed,
	input wire logic [3:0] o_sample_clock_value,
	input wire logic [7:1] o_status_flags
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_resetn);
	// Accepted write asking for a full status clear
	wire clr = i_write && o_claimed && i_address == 4'hF && i_write_data[0];
	key_gate_a: assert property (i_line_control_key != 8'hBF |-> !o_claimed)
		else $error("claimed without key");
	locked_write_a: assert property (i_write && !o_claimed && i_address == 4'h9
		|=> $stable(o_sample_clock_value)) else $error("locked write landed");
	flag_set_a: assert property (|i_status_events |=>
		(o_status_flags & $past(i_status_events)) == $past(i_status_events)) else $error("no set");
	flag_sticky_a: assert property (!clr |=>
		(o_status_flags & $past(o_status_flags)) == $past(o_status_flags)) else $error("flag lost");
	clear_all_a: assert property (clr && i_status_events == 7'h00 |=> o_status_flags == 7'h00)
		else $error("clear failed");
	clear_bit_a: assert property (i_read && o_claimed && i_address == 4'hF |=> !o_read_data[0])
		else $error("clear bit read 1");
	tx_level_a: assert property (i_read && o_claimed && i_address == 4'h6
		|=> o_read_data == $past(i_tx_fifo_level)) else $error("tx level");
	open_read_a: assert property (i_read && !o_claimed |=> o_read_data == 8'h00)
		else $error("unclaimed read");
	cover property (clr);
	cover property (|i_status_events);
	cover property (i_write && !o_claimed);
	cover property (i_read && o_claimed && i_address == 4'h5);
endmodule // efr_checker_sva
`default_nettype wire

// [verif/testbench.sv]
// Self-checking bench for the enhanced-feature register group
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic       i_clock = 1'b0;
	logic       rstn    = 1'b0;
	logic [7:0] key     = 8'h00;
	logic [7:0] tx_lvl  = 8'h00;
	logic [7:0] rx_lvl  = 8'h00;
	logic [7:0] err_cnt = 8'h00;
	logic [7:1] events  = 7'h00;
	logic [7:0] q;
	wire  [3:0] addr, pm, pn;
	wire        wr_en, rd_en, claimed;
	wire  [7:0] wdata, rdata, ctl, idle;
	wire  [4:0] sf;
	wire  [7:1] flags;
	int n_fail = 0;
	int checks_done = 0;
	// Rows: offset, value written, value read back
	logic [19:0] rows [3] = '{20'h8A5A5, 20'h9F1F1, 20'h43C3C};
	efr_host_model u_host (.i_clock(i_clock), .o_address(addr), .o_write(wr_en),
		.o_read(rd_en), .o_write_data(wdata), .i_read_data(rdata));
	uart_enhanced_feature_registers u_uart_enhanced_feature_registers (
		.i_clock(i_clock), .i_resetn(rstn), .i_address(addr), .i_write(wr_en),
		.i_read(rd_en), .i_write_data(wdata), .o_read_data(rdata), .o_claimed(claimed),
		.i_line_control_key(key), .i_tx_fifo_level(tx_lvl), .i_rx_fifo_level(rx_lvl),
		.i_rx_error_byte_count(err_cnt), .i_status_events(events),
		.o_xtal_feedback_disable(sf[4]), .o_burst_enable(sf[3]), .o_internal_loopback(sf[2]),
		.o_dsr_dtr_flow_enable(sf[1]), .o_force_transmit(sf[0]), .o_prescaler_m(pm),
		.o_prescaler_n(pn), .o_tx_idle_time(idle), .o_sample_clock_value(ctl[7:4]),
		.o_xon_enable(ctl[3]), .o_tx_empty_int_enable(ctl[2]), .o_rx_timeout_enable(ctl[1]),
		.o_idle_insert_enable(ctl[0]), .o_status_flags(flags));
	// Clock
	always #4 i_clock = ~i_clock;
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
	begin
		checks_done++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	end
	endtask
	task automatic report_and_stop;
	begin
		$display("checks %0d fails %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	end
	endtask
	// Main sequence: reset values, keys, table, counters, status
	initial
	begin
		repeat (10) @(posedge i_clock);
		chk(ctl, 8'h06);
		chk({3'h0, sf} | idle, 8'h00);
		chk({pm, pn}, 8'h10);
		rstn <= 1'b1;
		u_host.wr(4'h9, 8'hFF);
		u_host.rd(4'h9, q);
		chk(q | ctl, 8'h06);
		@(posedge i_clock) key <= 8'hBF;
		u_host.wr(4'h7, 8'h1B);
		chk({3'h0, sf}, 8'h00);
		u_host.wr(4'hD, 8'h5A);
		u_host.wr(4'h7, 8'h04);
		foreach (rows[i])
		begin
			u_host.wr(rows[i][19:16], rows[i][15:8]);
			u_host.rd(rows[i][19:16], q);
			chk(q, rows[i][7:0]);
		end
		chk({pm, pn}, 8'h3C);
		u_host.wr(4'h9, 8'hBD);
		chk(ctl, 8'hBD);
		u_host.wr(4'h7, 8'h9F);
		chk({3'h0, sf}, 8'h1F);
		$display("registers done");
		@(posedge i_clock) {tx_lvl, rx_lvl, err_cnt} <= 24'h402103;
		u_host.rd(4'h6, q);
		chk(q, 8'h40);
		u_host.rd(4'h5, q);
		chk(q, 8'h21);
		u_host.wr(4'h7, 8'hDF);
		u_host.rd(4'h5, q);
		chk(q, 8'h03);
		$display("counters done");
		@(posedge i_clock) events <= 7'h55;
		@(posedge i_clock) events <= 7'h2A;
		@(posedge i_clock) events <= 7'h00;
		u_host.rd(4'hF, q);
		chk(q, 8'hFE);
		u_host.wr(4'hF, 8'h01);
		chk({flags, 1'b0}, 8'h00);
		u_host.wr(4'h7, 8'h00);
		u_host.wr(4'h8, 8'h77);
		chk(idle, 8'hA5);
		chk({7'h00, claimed}, 8'h00);
		$display("status done");
		report_and_stop;
	end
	// Watchdog: whole run needs well under 300 cycles
	initial
	begin
		repeat (2000) @(posedge i_clock);
		n_fail++;
		report_and_stop;
	end
endmodule // testbench
bind uart_enhanced_feature_registers efr_checker_sva u_chk (.*);
`default_nettype wire
